// ==== rpmc_pkg.sv ====
// Constants shared by the reset and power-mode controller and its helpers.
// Assumes one oscillator-rate clock and a core that reaches the power
// control register over a simple byte-wide special-function register port.
package rpmc_pkg;

  // Clock and machine-cycle timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned OSC_PER_STATE  = 2;   // Input clock halved
  localparam int unsigned STATES_PER_MC  = 6;
  localparam int unsigned OSC_PER_MC     = OSC_PER_STATE * STATES_PER_MC;
  localparam int unsigned SAMPLE_STATE   = 5;
  localparam int unsigned SAMPLE_PHASE   = 2;
  localparam int unsigned RST_MIN_MC     = 2;   // Machine cycles of high reset

  localparam logic [3:0]  MC_LAST_IDX    = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  SAMPLE_IDX     =
    4'((SAMPLE_STATE - 1) * OSC_PER_STATE + SAMPLE_PHASE - 1);
  localparam logic [1:0]  RST_TRIP_CNT   = 2'(RST_MIN_MC - 1);

  // Register addresses
  localparam logic [7:0]  POWER_CONTROL_REG_ADDR      = 8'h87;
  localparam logic [7:0]  SERIAL_BUFFER_REG_ADDR      = 8'hF1;

  // Power control register fields
  localparam int unsigned IDLE_BIT       = 0;
  localparam int unsigned PD_BIT         = 1;
  localparam int unsigned GF0_BIT        = 2;
  localparam int unsigned GF1_BIT        = 3;
  localparam int unsigned POF_BIT        = 4;
  localparam logic [7:0]  POWER_CONTROL_REG_WR_MASK   = 8'h1F;
  localparam logic [7:0]  POWER_CONTROL_REG_KEEP_MASK = 8'h10;
  localparam logic [7:0]  POWER_CONTROL_REG_POR_VAL   = 8'h10;

  // Reset values loaded into the core
  localparam logic [7:0]  PORT_RESET_VAL = 8'hFF;
  localparam logic [7:0]  SP_RESET_VAL   = 8'h07;
  localparam logic [7:0]  SFR_RESET_VAL  = 8'h00;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN
  } pmode_type;

endpackage

// ==== machine_timer.sv ====
// Machine-cycle phase counter: divides the input clock by two into states
// and marks the sample point of each machine cycle.
// Assumes run_i drops while the oscillator is stopped.
`timescale 1ns/100ps
module machine_timer
  import rpmc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic run_i,
  output logic      state_tick_o,
  output logic      sample_o
);

  logic [3:0] idx_ff;
  logic       tick_ff;
  logic       sample_ff;

  // Oscillator period index inside the machine cycle
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      idx_ff <= 4'h0;
    end else if (run_i) begin
      idx_ff <= (idx_ff == MC_LAST_IDX) ? 4'h0 : idx_ff + 4'h1;
    end
  end

  // One state per two input periods, so duty cycle never matters
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= run_i & idx_ff[0];
    end
  end

  // Single sample strobe per machine cycle
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sample_ff <= 1'b0;
    end else begin
      sample_ff <= run_i & (idx_ff == SAMPLE_IDX);
    end
  end

  assign state_tick_o = tick_ff;
  assign sample_o     = sample_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_tick_half_rate: assert property (tick_ff |=> !tick_ff)
    else $error("state tick not at half the input rate");
  a_sample_point: assert property (sample_ff |-> $past(idx_ff) == SAMPLE_IDX)
    else $error("reset sampled outside its phase");

endmodule

// ==== reset_filter.sv ====
// Reset pin filter: a reset starts only after the pin reads high at the
// sample point of consecutive machine cycles; single samples are glitches.
// Assumes level_i is already synchronised to core_clk_i.
`timescale 1ns/100ps
module reset_filter
  import rpmc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic sample_i,
  input  wire logic level_i,
  input  wire logic clear_i,
  output logic      rst_o
);

  logic [1:0] hi_cnt_ff;
  logic       rst_ff;

  // Count consecutive high samples; stale counts die with the oscillator
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || clear_i) begin
      hi_cnt_ff <= 2'h0;
    end else if (sample_i) begin
      if (!level_i) begin
        hi_cnt_ff <= 2'h0;
      end else if (hi_cnt_ff != RST_TRIP_CNT) begin
        hi_cnt_ff <= hi_cnt_ff + 2'h1;
      end
    end
  end

  // Reset level follows the filtered pin
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rst_ff <= 1'b0;
    end else if (sample_i) begin
      rst_ff <= level_i & (hi_cnt_ff == RST_TRIP_CNT);
    end
  end

  assign rst_o = rst_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_rst_needs_two: assert property ($rose(rst_ff) |->
    $past(hi_cnt_ff) == RST_TRIP_CNT && $past(level_i))
    else $error("reset started without enough high samples");
  a_glitch_drops: assert property (sample_i && !level_i |=> !rst_ff)
    else $error("low sample did not end reset");

endmodule

// ==== reset_power_ctrl.sv ====
// Reset and power-mode controller: machine timing, reset pin filtering,
// idle and power-down control, power control and serial buffer registers.
// Assumes the core drives the register port on core_clk_i and that
// irq_i is the OR of all pending interrupt requests on the same clock.
`timescale 1ns/100ps

module reset_power_ctrl
  import rpmc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       rst_pin_i,
  input  wire logic       irq_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            osc_en_o,
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            sys_rst_o,
  output logic      [7:0] port_init_o,
  output logic      [7:0] sp_init_o,
  output logic      [7:0] sfr_init_o,
  output logic            idle_o,
  output logic            pdown_o,
  output logic      [7:0] power_control_reg_o
);

  logic       pin_meta_ff;
  logic       pin_sync_ff;
  logic       osc_run;
  logic       state_tick;
  logic       sample_s5p2;
  logic       ext_rst;
  pmode_type  mode_ff;
  pmode_type  nxt_mode;
  logic [7:0] power_control_reg_ff;
  logic [7:0] serial_buffer_reg_ff;
  logic [7:0] rdata_ff;
  logic [7:0] port_init_ff;
  logic [7:0] sp_init_ff;
  logic [7:0] sfr_init_ff;
  logic       power_control_reg_wr;
  logic       serial_buffer_reg_wr;
  logic       idle_wake;

  // Address decode of the register port
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  assign power_control_reg_wr   = sfr_wr_i & hit(sfr_addr_i, POWER_CONTROL_REG_ADDR);
  assign serial_buffer_reg_wr   = sfr_wr_i & hit(sfr_addr_i, SERIAL_BUFFER_REG_ADDR);
  assign idle_wake = (mode_ff == MODE_IDLE) & irq_i;

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= rst_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Oscillator stops in power-down; a high reset pin restarts it so that
  // the filter can see the machine cycles it needs
  assign osc_run = (mode_ff != MODE_PDOWN) | pin_sync_ff;

  machine_timer u_timer (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .run_i        (osc_run),
    .state_tick_o (state_tick),
    .sample_o     (sample_s5p2)
  );

  reset_filter u_filter (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sample_i   (sample_s5p2),
    .level_i    (pin_sync_ff),
    .clear_i    (!osc_run),
    .rst_o      (ext_rst)
  );

  // Power mode selection; reset overrides everything, power-down beats idle
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_RUN: begin
        if (power_control_reg_wr && sfr_wdata_i[PD_BIT]) begin
          nxt_mode = MODE_PDOWN;
        end else if (power_control_reg_wr && sfr_wdata_i[IDLE_BIT]) begin
          nxt_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_i) begin
          nxt_mode = MODE_RUN;
        end
      end
      MODE_PDOWN: begin
        nxt_mode = MODE_PDOWN;
      end
      default: begin
        nxt_mode = MODE_RUN;
      end
    endcase
    if (ext_rst) begin
      nxt_mode = MODE_RUN;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_ff <= MODE_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Power control register; the power-off flag survives warm resets so
  // software can tell them from a cold start
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      power_control_reg_ff <= POWER_CONTROL_REG_POR_VAL;
    end else if (ext_rst) begin
      power_control_reg_ff <= power_control_reg_ff & POWER_CONTROL_REG_KEEP_MASK;
    end else if (power_control_reg_wr) begin
      power_control_reg_ff <= sfr_wdata_i & POWER_CONTROL_REG_WR_MASK;
    end else if (idle_wake) begin
      power_control_reg_ff[IDLE_BIT] <= 1'b0;
    end
  end

  // Serial buffer holds its data across warm resets
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      serial_buffer_reg_ff <= SFR_RESET_VAL;
    end else if (serial_buffer_reg_wr) begin
      serial_buffer_reg_ff <= sfr_wdata_i;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= SFR_RESET_VAL;
    end else if (hit(sfr_addr_i, POWER_CONTROL_REG_ADDR)) begin
      rdata_ff <= power_control_reg_ff;
    end else if (hit(sfr_addr_i, SERIAL_BUFFER_REG_ADDR)) begin
      rdata_ff <= serial_buffer_reg_ff;
    end else begin
      rdata_ff <= SFR_RESET_VAL;
    end
  end

  // Values the core loads while sys_rst_o is high
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      port_init_ff <= PORT_RESET_VAL;
      sp_init_ff   <= SP_RESET_VAL;
      sfr_init_ff  <= SFR_RESET_VAL;
    end else if (ext_rst) begin
      port_init_ff <= PORT_RESET_VAL;
      sp_init_ff   <= SP_RESET_VAL;
      sfr_init_ff  <= SFR_RESET_VAL;
    end
  end

  // Clock enables follow the mode; the core stays clocked during reset
  // so it can load its reset values
  assign cpu_clk_en_o    = state_tick & (mode_ff == MODE_RUN);
  assign periph_clk_en_o = state_tick & (mode_ff != MODE_PDOWN);
  assign osc_en_o        = osc_run;
  assign sys_rst_o       = ext_rst;
  assign port_init_o     = port_init_ff;
  assign sp_init_o       = sp_init_ff;
  assign sfr_init_o      = sfr_init_ff;
  assign idle_o          = (mode_ff == MODE_IDLE);
  assign pdown_o         = (mode_ff == MODE_PDOWN);
  assign power_control_reg_o          = power_control_reg_ff;
  assign sfr_rdata_o     = rdata_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_idle_entry: assert property (mode_ff == MODE_RUN && !ext_rst && power_control_reg_wr
    && sfr_wdata_i[IDLE_BIT] && !sfr_wdata_i[PD_BIT] |=> mode_ff == MODE_IDLE)
    else $error("idle request did not enter idle");
  a_idle_cpu_gate: assert property (mode_ff == MODE_IDLE |-> !cpu_clk_en_o)
    else $error("processor clocked in idle");
  a_idle_periph_on: assert property (mode_ff == MODE_IDLE && state_tick
    |-> periph_clk_en_o)
    else $error("peripherals stopped in idle");
  a_idle_wake: assert property (idle_wake |=> mode_ff == MODE_RUN
    && !power_control_reg_ff[IDLE_BIT])
    else $error("interrupt did not end idle");
  a_pd_entry: assert property (mode_ff == MODE_RUN && !ext_rst && power_control_reg_wr
    && sfr_wdata_i[PD_BIT] |=> mode_ff == MODE_PDOWN)
    else $error("power-down request ignored");
  a_pd_clocks_off: assert property (mode_ff == MODE_PDOWN && !pin_sync_ff
    |-> !osc_en_o && !cpu_clk_en_o ##1 !periph_clk_en_o && !cpu_clk_en_o)
    else $error("clock running in power-down");
  a_pd_only_reset: assert property (mode_ff == MODE_PDOWN && !ext_rst
    |=> mode_ff == MODE_PDOWN)
    else $error("power-down left without reset");
  a_rst_power_control_reg_clr: assert property (ext_rst |=> power_control_reg_ff[3:0] == 4'h0
    && power_control_reg_ff[POF_BIT] == $past(power_control_reg_ff[POF_BIT]))
    else $error("power control not cleared by reset");
  a_rst_serial_buffer_reg_kept: assert property (ext_rst && !serial_buffer_reg_wr
    |=> $stable(serial_buffer_reg_ff))
    else $error("serial buffer changed by reset");
  a_rst_load_vals: assert property (ext_rst |=> port_init_o == PORT_RESET_VAL
    && sp_init_o == SP_RESET_VAL && sfr_init_o == SFR_RESET_VAL)
    else $error("wrong reset load values");

  // A warm reset always returns the controller to run mode
  a_rst_ends_mode: assert property (ext_rst |=> mode_ff == MODE_RUN)
    else $error("reset did not return to run mode");

  // Power-down wins when both request bits arrive in one write
  a_pd_beats_idle: assert property (mode_ff == MODE_RUN && !ext_rst && power_control_reg_wr
    && sfr_wdata_i[PD_BIT] && sfr_wdata_i[IDLE_BIT] |=> mode_ff == MODE_PDOWN)
    else $error("idle chosen over power-down");

  // Peripherals lose their clock in power-down as well
  a_pd_periph_off: assert property (mode_ff == MODE_PDOWN |-> !periph_clk_en_o)
    else $error("peripheral clock running in power-down");

  // A high reset pin must restart the oscillator, or reset is never seen
  a_pd_osc_wake: assert property (mode_ff == MODE_PDOWN && pin_sync_ff
    |-> osc_en_o)
    else $error("oscillator held off with reset pin high");

  // Processor enable never runs faster than the halved input clock
  a_cpu_half_rate: assert property (cpu_clk_en_o |=> !cpu_clk_en_o)
    else $error("processor enable faster than half rate");

  // Writes land through the mask; reset beats a write
  a_power_control_reg_write: assert property (power_control_reg_wr && !ext_rst
    |=> power_control_reg_ff == ($past(sfr_wdata_i) & POWER_CONTROL_REG_WR_MASK))
    else $error("power control write lost");

  // Unused upper bits of power control always read zero
  a_power_control_reg_upper_zero: assert property (power_control_reg_ff[7:5] == 3'h0)
    else $error("power control upper bits set");

  // Only software or power-on may raise the power-off flag
  a_pof_no_set: assert property (!power_control_reg_wr && !power_control_reg_ff[POF_BIT]
    |=> !power_control_reg_ff[POF_BIT])
    else $error("power-off flag set by hardware");

  // Serial buffer takes written data in the next cycle
  a_serial_buffer_reg_write: assert property (serial_buffer_reg_wr |=> serial_buffer_reg_ff == $past(sfr_wdata_i))
    else $error("serial buffer write lost");

  // Read data of power control lags the address by one cycle
  a_rdata_power_control_reg: assert property (hit(sfr_addr_i, POWER_CONTROL_REG_ADDR)
    |=> sfr_rdata_o == $past(power_control_reg_ff))
    else $error("power control read wrong");

  // Unmapped addresses read as zero
  a_rdata_unmapped: assert property (!hit(sfr_addr_i, POWER_CONTROL_REG_ADDR)
    && !hit(sfr_addr_i, SERIAL_BUFFER_REG_ADDR) |=> sfr_rdata_o == SFR_RESET_VAL)
    else $error("unmapped address read nonzero");

  // Scenario covers: both request bits in one write is a corner worth seeing

  c_idle_cycle: cover property (mode_ff == MODE_IDLE ##[1:50] mode_ff == MODE_RUN);
  c_pd_reset: cover property (mode_ff == MODE_PDOWN ##[1:100] ext_rst);
  c_warm_reset: cover property ($rose(ext_rst) && power_control_reg_ff[POF_BIT]);
  c_pd_both_bits: cover property (power_control_reg_wr && sfr_wdata_i[PD_BIT] && sfr_wdata_i[IDLE_BIT]);

endmodule

// ==== ext_reset_net.sv ====
// Far-side model: external reset network on the reset pin, interrupt source.
// Assumes calls start just after a rising edge; the pin idles low (pull-down).
`timescale 1ns/100ps
module ext_reset_net (
  input  wire logic core_clk_i,
  output logic      rst_pin_o,
  output logic      irq_o
);
  localparam int MC_CLKS = 12;  // Input clocks per machine cycle

  // Released lines rest low through the pull-down
  initial begin
    rst_pin_o = 1'b0;
    irq_o     = 1'b0;
  end

  // Pin high for n clocks; a short one is a glitch the bench asks for
  task automatic drive_pin(input int n);
    rst_pin_o = 1'b1;
    repeat (n) @(posedge core_clk_i);
    #1 rst_pin_o = 1'b0;
  endtask

  // Genuine reset: at least two machine cycles plus some slack
  task automatic hold_reset(input int extra);
    drive_pin(2 * MC_CLKS + extra);
  endtask

  // Interrupt request held for n clocks
  task automatic pulse_irq(input int n);
    irq_o = 1'b1;
    repeat (n) @(posedge core_clk_i);
    #1 irq_o = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the reset and power-mode controller.
// Assumes ext_reset_net plays the reset network and interrupt source.
`timescale 1ns/100ps
module testbench import rpmc_pkg::*;;
  logic       clk;
  logic       rstn;
  logic       pin;
  logic       irq;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata, port_init, sp_init, sfr_init, power_control_reg, m, flags;
  logic       osc_en, cpu_en, per_en, sys_rst, idle, pdown;
  int         miscompares, checked, exp_power_control_reg, exp_serial_buffer_reg, k, c, p;

  // Free-running 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  reset_power_ctrl dut (
    .core_clk_i      (clk),
    .resetn_i        (rstn),
    .rst_pin_i       (pin),
    .irq_i           (irq),
    .sfr_wr_i        (wr_en),
    .sfr_addr_i      (addr),
    .sfr_wdata_i     (wdata),
    .sfr_rdata_o     (rdata),
    .osc_en_o        (osc_en),
    .cpu_clk_en_o    (cpu_en),
    .periph_clk_en_o (per_en),
    .sys_rst_o       (sys_rst),
    .port_init_o     (port_init),
    .sp_init_o       (sp_init),
    .sfr_init_o      (sfr_init),
    .idle_o          (idle),
    .pdown_o         (pdown),
    .power_control_reg_o          (power_control_reg)
  );

  ext_reset_net rn (
    .core_clk_i (clk),
    .rst_pin_o  (pin),
    .irq_o      (irq)
  );

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One write plus a quiet cycle, so the strobe never toggles twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    cyc();
    wr_en = 1'b0;
    cyc();
    if (a == 8'h87)
      exp_power_control_reg = d & 8'h1F;
    if (a == SERIAL_BUFFER_REG_ADDR)
      exp_serial_buffer_reg = d;
  endtask

  // Read data lags the address by one cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    addr = a;
    cyc();
    chk(nm, rdata, exp);
  endtask

  // Counts processor and peripheral enable pulses over n cycles
  task automatic cnt(input int n);
    c = 0;
    p = 0;
    repeat (n) begin
      if (cpu_en === 1'b1)
        c++;
      if (per_en === 1'b1)
        p++;
      cyc();
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 250 cycles
  initial begin
    #(40 * 5000);
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    miscompares = 0;
    checked = 0;
    exp_power_control_reg = 8'h10;
    exp_serial_buffer_reg = 0;
    k = $urandom(32'hFF25E52C);
    cyc(6);
    rstn = 1'b1;
    chk("power_control_reg", power_control_reg, 8'(exp_power_control_reg));
    chk("port_init", port_init, 8'hFF);
    chk("sp_init", sp_init, 8'h07);
    chk("sfr_init", sfr_init, 8'h00);
    cyc(4);
    cnt(24);
    chk("cpu pulses", 8'(c), 8'h0C);
    chk("per pulses", 8'(p), 8'h0C);
    m = 8'($urandom);
    wr(SERIAL_BUFFER_REG_ADDR, m);
    rd(SERIAL_BUFFER_REG_ADDR, 8'(exp_serial_buffer_reg), "serial_buffer_reg");
    rd(8'h87, 8'(exp_power_control_reg), "power_control_reg read");
    do
      k = $urandom_range(255);
    while (k == 8'h87 || k == SERIAL_BUFFER_REG_ADDR);
    wr(8'(k), 8'h0F);
    rd(8'(k), 8'h00, "unmapped");
    chk("power_control_reg", power_control_reg, 8'(exp_power_control_reg));
    flags = 8'($urandom) & 8'h0C;
    wr(8'h87, flags);
    chk("flags", power_control_reg, 8'(exp_power_control_reg));
    wr(8'h87, flags | 8'h10);
    // A pin pulse shorter than a machine cycle is a glitch
    k = 0;
    fork
      rn.drive_pin(6);
      repeat (60) begin
        cyc();
        if (sys_rst === 1'b1)
          k = 1;
      end
    join
    chk("glitch", 8'(k), 8'h00);
    // Idle then power-down: interrupt reaction, clocks, pin reset exit
    for (int i = 1; i <= 2; i++) begin
      m = 8'(i);
      wr(8'h87, m | flags | 8'h10);
      chk("idle", {7'h00, idle}, {7'h00, m[0]});
      chk("pdown", {7'h00, pdown}, {7'h00, m[1]});
      rn.pulse_irq(3);
      if (m[0])
        exp_power_control_reg = exp_power_control_reg & 8'hFE;
      chk("power_control_reg irq", power_control_reg, 8'(exp_power_control_reg));
      chk("pdown irq", {7'h00, pdown}, {7'h00, m[1]});
      if (m[0])
        wr(8'h87, 8'(exp_power_control_reg) | 8'h01);
      cnt(12);
      chk("cpu pulses", 8'(c), 8'h00);
      chk("per pulses", 8'(p), m[0] ? 8'h06 : 8'h00);
      chk("osc", {7'h00, osc_en}, {7'h00, m[0]});
      k = 0;
      fork
        rn.hold_reset(16);
        while (sys_rst !== 1'b1 && k < 80) begin
          cyc();
          k++;
        end
      join
      chk("rst delay", 8'(k >= 13 && k <= 45), 8'h01);
      k = 0;
      while (sys_rst !== 1'b0 && k < 40) begin
        cyc();
        k++;
      end
      exp_power_control_reg = exp_power_control_reg & 8'h10;
      chk("power_control_reg rst", power_control_reg, 8'(exp_power_control_reg));
      chk("modes", {6'h00, pdown, idle}, 8'h00);
      chk("osc", {7'h00, osc_en}, 8'h01);
      rd(SERIAL_BUFFER_REG_ADDR, 8'(exp_serial_buffer_reg), "serial_buffer_reg kept");
      chk("port_init", port_init, 8'hFF);
      chk("sp_init", sp_init, 8'h07);
    end
    end_of_test();
  end
endmodule
